// >>> hw/mhp_host_port.sv
`timescale 1ns/1ps
// Behaviour
// - Receive client outputs follow receive application clock.
// - Receive application clock comes from line receive.
// - Transmit clock: system at 1G, PHY otherwise.
// - Serial-gigabit option fixes both clocks at 125.
// - Management clock used only when module built.
// - Reset clears registers; outputs except clocks and byte advance strobes go inactive.
// - Gigabit indication mirrors mode bit zero.
// - Host bus timed by host clock only.
// - Strobes ignored while chip select high.
// - Eight-bit address picks the target register.
// - Write strobe stores data in addressed register.
// - Read strobe returns addressed register contents.
// - Ready on write only after data stored.
// - Ready on read only with valid data.
// - Output enable low while read data valid.
module mhp_host_port #(
	parameter int REG_COUNT = mhp_pkg::MHP_REG_COUNT,
	parameter bit SGMII_OPT = 1'b0,
	parameter bit HAS_MGMT  = 1'b0
) (
	// Host clock and reset.
	input  wire logic       clk,
	input  wire logic       rst_n,
	// Host register bus.
	input  wire logic       hcs_n,
	input  wire logic [7:0] haddr,
	input  wire logic [7:0] hdatain,
	input  wire logic       hwrite_n,
	input  wire logic       hread_n,
	output logic            hready_n,
	output logic [7:0]      hdataout,
	output logic            hdataout_en_n,
	// Clock sources and application clocks.
	input  wire logic       sys_clk,
	input  wire logic       phy_rx_clk,
	input  wire logic       phy_tx_clk,
	output logic            rxmac_clk,
	output logic            txmac_clk,
	// Serial-gigabit clock enables and byte advance strobes.
	input  wire logic       rx_clk_en,
	input  wire logic       tx_clk_en,
	output logic            rx_byte_adv,
	output logic            tx_byte_adv,
	// Management clock.
	input  wire logic       mdc,
	output logic            mdc_rise,
	// Mode indication.
	output logic            gbit_en
);
	import mhp_pkg::*;

	////////////////////////////////////////////////////////////////////////
	mhp_state_type  state;
	mhp_state_type  next_state;
	logic [7:0]     regs [REG_COUNT];
	logic [7:0]     next_regs [REG_COUNT];
	logic [7:0]     rdata;
	logic [7:0]     next_rdata;
	logic           oe_n;
	logic           next_oe_n;
	logic           sel_wr;
	logic           sel_rd;
	logic           in_range;
	logic [MHP_SYNC_LEN-1:0] mdc_sync;
	logic [MHP_SYNC_LEN-1:0] next_mdc_sync;

	// Addresses beyond the file read as zero and ignore writes.
	// address decode
	assign in_range = (32'(haddr) < REG_COUNT);
	assign sel_wr = !hcs_n && !hwrite_n;
	assign sel_rd = !hcs_n && !hread_n && hwrite_n;

	// Next state of the host handshake; write wins over read.
	always_comb begin
		next_state = state;
		next_rdata = rdata;
		next_oe_n  = oe_n;
		unique case (state)
			MHP_IDLE: begin
				if (sel_wr) begin
					next_state = MHP_ACK;
				end else if (sel_rd) begin
					next_rdata = in_range ? regs[haddr[3:0]] : 8'h00;
					next_oe_n  = 1'b0;
					next_state = MHP_ACK;
				end
			end
			MHP_ACK: begin
				// The access ends once the host drops its strobe or select.
				if (hcs_n || (hwrite_n && hread_n)) begin
					next_state = MHP_IDLE;
					next_oe_n  = 1'b1;
				end
			end
		endcase
	end

	// Host clock only; the application clocks never touch this state.
	// host clock timing
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= MHP_IDLE;
			rdata <= 8'h00;
			oe_n  <= 1'b1;
		end else begin
			state <= next_state;
			rdata <= next_rdata;
			oe_n  <= next_oe_n;
		end
	end

	// Register file; the write lands on the same edge that starts ACK.
	// store write data
	always_comb begin
		next_regs = regs;
		if (state == MHP_IDLE && sel_wr && in_range) begin
			next_regs[haddr[3:0]] = hdatain;
		end
	end

	// Register file flops; reset returns every byte to its reset value.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < REG_COUNT; i++) begin
				regs[i] <= MHP_REG_RESET;
			end
		end else begin
			regs <= next_regs;
		end
	end

	// Ready follows the stored write or the latched read data.
	// ready after write
	assign hready_n      = (state != MHP_ACK);
	assign hdataout      = rdata;
	assign hdataout_en_n = oe_n;

	assign gbit_en = regs[MHP_MODE_ADDR[3:0]][MHP_GBIT_POS];

	////////////////////////////////////////////////////////////////////////
	// Clock routing. This is a plain mux; a glitch-free switch is left to
	// the clock network, so change the mode only while the link is idle.
	// receive clock source
	assign rxmac_clk = SGMII_OPT ? sys_clk : phy_rx_clk;
	assign txmac_clk = (SGMII_OPT || gbit_en) ? sys_clk : phy_tx_clk;

	// Byte advance strobes for the datapaths; always on outside the option.
	// enable gated advance
	assign rx_byte_adv = SGMII_OPT ? rx_clk_en : 1'b1;
	assign tx_byte_adv = SGMII_OPT ? tx_clk_en : 1'b1;

	////////////////////////////////////////////////////////////////////////
	// Management clock sampled by three flops; only the last two are compared.
	always_comb begin
		next_mdc_sync = {mdc_sync[MHP_SYNC_LEN-2:0], mdc};
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mdc_sync <= '0;
		end else begin
			mdc_sync <= next_mdc_sync;
		end
	end

	assign mdc_rise = HAS_MGMT && mdc_sync[1] && !mdc_sync[2];

	////////////////////////////////////////////////////////////////////////
	// Checks on the host port and the clocking front end.
	chk_write_mode: assert property (@(posedge clk) disable iff (!rst_n)
		(state == MHP_IDLE && sel_wr && haddr == MHP_MODE_ADDR)
		|=> (gbit_en == $past(hdatain[MHP_GBIT_POS])) && !hready_n)
		else $error("mode write not stored before ready");

	chk_gbit_hold: assert property (@(posedge clk) disable iff (!rst_n)
		!(state == MHP_IDLE && sel_wr && haddr == MHP_MODE_ADDR)
		|=> $stable(gbit_en))
		else $error("gigabit indication changed without a write");

	chk_cs_ignore: assert property (@(posedge clk) disable iff (!rst_n)
		(state == MHP_IDLE && hcs_n) |=> hready_n)
		else $error("ready asserted without chip select");

	chk_read_data: assert property (@(posedge clk) disable iff (!rst_n)
		(state == MHP_IDLE && sel_rd && haddr == MHP_MODE_ADDR)
		|=> !hready_n && hdataout == $past(regs[MHP_MODE_ADDR[3:0]]))
		else $error("read data not valid with ready");

	chk_oe_ready: assert property (@(posedge clk) disable iff (!rst_n)
		!hdataout_en_n |-> !hready_n && hwrite_n)
		else $error("output enable without read ready");

	chk_ready_held: assert property (@(posedge clk) disable iff (!rst_n)
		(!hready_n && !hcs_n && !hwrite_n) |=> !hready_n)
		else $error("ready dropped while write still held");

	chk_reset_idle: assert property (@(posedge clk)
		!rst_n |-> hready_n && hdataout_en_n && !mdc_rise)
		else $error("outputs active during reset");

	chk_byte_gate: assert property (@(posedge clk) disable iff (!rst_n)
		(SGMII_OPT && !rx_clk_en) |-> !rx_byte_adv)
		else $error("receive advanced without enable");

	chk_mdc_unused: assert property (@(posedge clk) disable iff (!rst_n)
		!HAS_MGMT |-> !mdc_rise)
		else $error("management clock used without module");

	chk_tx_gate: assert property (@(posedge clk) disable iff (!rst_n)
		(SGMII_OPT && !tx_clk_en) |-> !tx_byte_adv)
		else $error("transmit advanced without enable");

	chk_mdc_pulse: assert property (@(posedge clk) disable iff (!rst_n)
		mdc_rise |=> !mdc_rise)
		else $error("management edge pulse longer than one cycle");

	cov_write: cover property (@(posedge clk) disable iff (!rst_n)
		sel_wr ##1 !hready_n ##1 hready_n);
	cov_read: cover property (@(posedge clk) disable iff (!rst_n)
		sel_rd ##1 !hdataout_en_n);
	cov_gbit: cover property (@(posedge clk) disable iff (!rst_n)
		$rose(gbit_en));
	cov_byte_pulse: cover property (@(posedge clk) disable iff (!rst_n)
		SGMII_OPT && rx_byte_adv ##1 !rx_byte_adv);

endmodule // mhp_host_port

// >>> hw/mhp_pkg.sv
package mhp_pkg;
	// Register map and field layout.
	localparam logic [7:0] MHP_MODE_ADDR  = 8'h00;
	localparam int         MHP_GBIT_POS   = 0;
	localparam logic [7:0] MHP_REG_RESET  = 8'h00;
	localparam int         MHP_REG_COUNT  = 16;
	// Timing of the serial-gigabit clock enables, in 125 MHz cycles.
	localparam int         MHP_CE_DIV_100 = 10;
	localparam int         MHP_CE_DIV_10  = 100;
	localparam int         MHP_SYNC_LEN   = 3;
	// Host handshake states.
	typedef enum logic {MHP_IDLE, MHP_ACK} mhp_state_type;
endpackage

// >>> bench/mhp_host_model.sv
`timescale 1ns/1ps
// Host processor on the register bus, one access at a time.
module mhp_host_model (
	// Bus clock.
	input  wire logic       clk,
	// Host register bus.
	output logic            hcs_n,
	output logic [7:0]      haddr,
	output logic [7:0]      hdatain,
	output logic            hwrite_n,
	output logic            hread_n,
	input  wire logic       hready_n,
	input  wire logic [7:0] hdataout,
	input  wire logic       hdataout_en_n
);
	// Idle bus at time zero.
	initial begin
		hcs_n = 1'b1;
		hwrite_n = 1'b1;
		hread_n = 1'b1;
		haddr = 8'h00;
		hdatain = 8'h00;
	end
	////////////////////////////////////////////////////////////
	// launch after edge.
	task automatic access(input logic cs_n, wr, input logic [7:0] a, d,
		output logic [9:0] q);
		int n;
		n = 0;
		@(posedge clk);
		#1;
		hcs_n = cs_n;
		haddr = a;
		hdatain = d;
		hwrite_n = !wr;
		hread_n = wr;
		// hold until ready; a bounded wait so a silent device cannot hang.
		do begin
			@(posedge clk);
			n++;
		end while (hready_n !== 1'b0 && n < 8);
		// Ready comes back too, so a refused access shows as not ready.
		q = {hready_n, hdataout_en_n, hdataout};
		#1;
		hcs_n = 1'b1;
		hwrite_n = 1'b1;
		hread_n = 1'b1;
		// Released lines show the inverse so stale values cannot pass.
		haddr = ~haddr;
		hdatain = ~hdatain;
		@(posedge clk);
	endtask
endmodule // mhp_host_model

// >>> bench/mhp_host_port_tb.sv
`timescale 1ns/1ps
module mhp_host_port_tb;
	import mhp_pkg::*;
	typedef struct packed {
		logic [7:0] a;
		logic [7:0] d;
		logic [7:0] e;
	} mhp_row_type;
	// Reset starts high so that its fall is seen by the core.
	logic        clk     = 1'b0;
	logic        sys_clk = 1'b0;
	logic        rx_ck   = 1'b0;
	logic        tx_ck   = 1'b0;
	logic        rst_n   = 1'b1;
	logic        ce      = 1'b1;
	logic        hcs_n, hwrite_n, hread_n, hready_n, hdataout_en_n;
	logic        rxc, txc, rxa, txa, mdc_rise, gbit_en, g;
	logic        rxo, txo, rxao, txao, mdco;
	logic [7:0]  haddr, hdatain, hdataout;
	logic [9:0]  q;
	int          bad_count, num_checks, cycles;
	int          ce_div  = 1;
	int          ce_cnt  = 0;
	mhp_row_type rows [5] = '{'{8'h00, 8'h01, 8'h01},
		'{8'h00, 8'ha6, 8'ha6}, '{8'h0f, 8'h5a, 8'h5a},
		'{8'h10, 8'hff, 8'h00}, '{8'h03, 8'hc3, 8'hc3}};
	// Host clock; the system clock is offset so checks never meet its edge.
	always #4 clk = ~clk;
	initial begin #2; forever #4 sys_clk = ~sys_clk; end
	initial begin #13; forever #80 rx_ck = ~rx_ck; end
	initial begin #57; forever #80 tx_ck = ~tx_ck; end
	mhp_host_model host (.clk(clk), .hcs_n(hcs_n), .haddr(haddr),
		.hdatain(hdatain), .hwrite_n(hwrite_n), .hread_n(hread_n),
		.hready_n(hready_n), .hdataout(hdataout), .hdataout_en_n(hdataout_en_n));
	mhp_host_port dut (.clk(clk), .rst_n(rst_n), .hcs_n(hcs_n), .haddr(haddr),
		.hdatain(hdatain), .hwrite_n(hwrite_n), .hread_n(hread_n),
		.hready_n(hready_n), .hdataout(hdataout), .hdataout_en_n(hdataout_en_n),
		.sys_clk(sys_clk), .phy_rx_clk(rx_ck), .phy_tx_clk(tx_ck),
		.rxmac_clk(rxc), .txmac_clk(txc), .rx_clk_en(ce), .tx_clk_en(ce),
		.rx_byte_adv(rxa), .tx_byte_adv(txa), .mdc(tx_ck),
		.mdc_rise(mdc_rise), .gbit_en(gbit_en));
	// Second core with the serial option and the management module built.
	mhp_host_port #(.SGMII_OPT(1'b1), .HAS_MGMT(1'b1)) dut_opt (
		.clk(clk), .rst_n(rst_n), .hcs_n(hcs_n), .haddr(haddr),
		.hdatain(hdatain), .hwrite_n(hwrite_n), .hread_n(hread_n),
		.hready_n(), .hdataout(), .hdataout_en_n(),
		.sys_clk(sys_clk), .phy_rx_clk(rx_ck), .phy_tx_clk(tx_ck),
		.rxmac_clk(rxo), .txmac_clk(txo), .rx_clk_en(ce), .tx_clk_en(ce),
		.rx_byte_adv(rxao), .tx_byte_adv(txao), .mdc(tx_ck),
		.mdc_rise(mdco), .gbit_en());
	// PCS enables: held high at 1G, else one pulse per divisor.
	always @(posedge clk) begin
		#1;
		ce_cnt = (ce_cnt + 1 >= ce_div) ? 0 : ce_cnt + 1;
		ce = (ce_cnt == 0);
	end
	////////////////////////////////////////////////////////////
	task automatic check(string name, logic [9:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Counts byte advances over a hundred cycles, sampled mid-cycle.
	task automatic count_adv(input int div);
		int nr, nt, nm, bad;
		nr = 0;
		nt = 0;
		nm = 0;
		bad = 0;
		ce_div = div;
		repeat (2) @(negedge clk);
		repeat (100) begin
			@(negedge clk);
			nr += rxao;
			nt += txao;
			nm += (rxa && txa);
			bad += ({rxo, txo} !== {2{sys_clk}});
		end
		check("rx adv", nr, 100 / div);
		check("tx adv", nt, 100 / div);
		check("plain adv", nm, 100);
		check("fixed clocks", bad, 0);
	endtask
	// One management clock period holds exactly one rising edge.
	task automatic count_mdc();
		int n, m;
		n = 0;
		m = 0;
		@(posedge tx_ck);
		repeat (20) begin
			@(negedge clk);
			n += mdco;
			m += mdc_rise;
		end
		check("mdc rise", n, 1);
		check("mdc unused", m, 0);
	endtask
	// A hang counts as a mismatch; the whole run needs far fewer cycles.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			bad_count++;
			give_verdict();
		end
	end
	// Table rows, then chip select, enables, management clock, mid-run reset.
	initial begin
		g = 1'b0;
		#1 rst_n = 1'b0;
		repeat (16) @(posedge clk);
		#1 rst_n = 1'b1;
		foreach (rows[i]) begin
			host.access(1'b0, 1'b1, rows[i].a, rows[i].d, q);
			if (rows[i].a == MHP_MODE_ADDR) g = rows[i].d[MHP_GBIT_POS];
			check("gbit", gbit_en, g);
			host.access(1'b0, 1'b0, rows[i].a, 8'h00, q);
			check("read", q[7:0], rows[i].e);
			check("read ready", q[9:8], 2'b00);
			check("txclk", txc, g ? sys_clk : tx_ck);
			check("rxclk", rxc, rx_ck);
			check("adv", {rxa, txa, mdc_rise}, 3'b110);
		end
		$display("row tests done");
		host.access(1'b1, 1'b1, 8'h03, 8'h11, q);
		check("no ready", q[9], 1'b1);
		host.access(1'b0, 1'b0, 8'h03, 8'h00, q);
		check("unselected", q, 10'h0c3);
		$display("select test done");
		count_adv(1);
		count_adv(MHP_CE_DIV_100);
		count_adv(MHP_CE_DIV_10);
		$display("enable test done");
		count_mdc();
		$display("management clock test done");
		host.access(1'b0, 1'b1, 8'h00, 8'h01, q);
		#3 rst_n = 1'b0;
		#1;
		check("reset", {hready_n, hdataout_en_n, gbit_en, mdc_rise}, 4'hc);
		check("reset data", hdataout, 8'h00);
		repeat (2) @(posedge clk);
		#1 rst_n = 1'b1;
		host.access(1'b0, 1'b0, 8'h00, 8'h00, q);
		check("cleared", q, 10'h000);
		$display("reset test done");
		give_verdict();
	end
endmodule // mhp_host_port_tb
